// File: rtl/sdtc_core.sv
// Training, write leveling and termination control of the memory device.
// Assumes mem_clk is the command clock from the controller, may stop between
// frames; status inputs come from device logic on ref_clk.
`timescale 1ns/1ns
`default_nettype none

module sdtc_core (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic mem_clk,
	input wire logic cs_n,
	input wire logic cke,
	input wire logic [sdtc_pkg::CA_W-1:0] ca,
	input wire logic odt_pin,
	input wire logic [sdtc_pkg::BYTES-1:0] dqs_t,
	input wire logic zq_busy,
	input wire logic read_active,
	input wire logic self_refresh,
	input wire logic deep_pd,
	input wire logic cke_pd,
	output logic [sdtc_pkg::DQ_W-1:0] dq_o,
	output logic dq_oe,
	output logic dq_term_en,
	output logic dqs_term_en,
	output logic [1:0] rtt_sel,
	output logic ca_training,
	output logic write_leveling
);

	// Link domain reset release
	logic lrst_a_r, lrst_n_r;
	always_ff @(posedge mem_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_a_r <= 1'b0;
			lrst_n_r <= 1'b0;
		end else begin
			lrst_a_r <= 1'b1;
			lrst_n_r <= lrst_a_r;
		end
	end

	// Rising edge capture
	logic cs_low_r, cke_r;
	logic [sdtc_pkg::CA_W-1:0] ca_rise_r;
	always_ff @(posedge mem_clk or negedge lrst_n_r) begin
		if (!lrst_n_r) begin
			cs_low_r <= 1'b0;
			cke_r <= 1'b0;
			ca_rise_r <= '0;
		end else begin
			cs_low_r <= ~cs_n;
			cke_r <= cke;
			ca_rise_r <= ca;
		end
	end

	// Whole frame ready only after the falling half; toggle marks it
	sdtc_pkg::sdtc_frame_s frame_r;
	logic frame_tgl_r;
	always_ff @(negedge mem_clk or negedge lrst_n_r) begin
		if (!lrst_n_r) begin
			frame_r <= '0;
			frame_tgl_r <= 1'b0;
		end else begin
			frame_r <= '{cs_low: cs_low_r, cke: cke_r, ca_rise: ca_rise_r, ca_fall: ca};
			frame_tgl_r <= ~frame_tgl_r;
		end
	end

	// Reference domain reset release
	logic rst_a_r, rst_ok_n;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_r <= 1'b0;
			rst_ok_n <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_ok_n <= rst_a_r;
		end
	end

	// Pin synchronisers; frame word is stable for a whole link period
	logic [2:0] tgl_s_r;
	logic [1:0] odt_s_r;
	logic [1:0] ck_s_r;
	logic [sdtc_pkg::BYTES-1:0] dqs_a_r, dqs_b_r, dqs_c_r;
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			tgl_s_r <= '0;
			odt_s_r <= '0;
			ck_s_r <= '0;
			dqs_a_r <= '0;
			dqs_b_r <= '0;
			dqs_c_r <= '0;
		end else if (clk_en) begin
			tgl_s_r <= {tgl_s_r[1:0], frame_tgl_r};
			odt_s_r <= {odt_s_r[0], odt_pin};
			ck_s_r <= {ck_s_r[0], mem_clk};
			dqs_a_r <= dqs_t;
			dqs_b_r <= dqs_a_r;
			dqs_c_r <= dqs_b_r;
		end
	end

	logic ev;
	logic [sdtc_pkg::BYTES-1:0] dqs_rise;
	assign ev = tgl_s_r[2] ^ tgl_s_r[1];
	assign dqs_rise = dqs_b_r & ~dqs_c_r;

	function automatic sdtc_pkg::sdtc_mrw_s mrw_fields(input sdtc_pkg::sdtc_frame_s f);
		mrw_fields.addr = {f.ca_fall[1:0], f.ca_rise[9:4]};
		mrw_fields.data = f.ca_fall[9:2];
	endfunction : mrw_fields

	function automatic logic [sdtc_pkg::DQ_W-1:0] train_map(input sdtc_pkg::sdtc_frame_s f,
		input logic second);
		logic [7:0] sel_r;
		logic [7:0] sel_f;
		sel_r = {f.ca_rise[8:5], f.ca_rise[3:0]};
		sel_f = {f.ca_fall[8:5], f.ca_fall[3:0]};
		train_map = '0;
		if (second) begin
			train_map[0] = f.ca_rise[4];
			train_map[1] = f.ca_fall[4];
			train_map[8] = f.ca_rise[9];
			train_map[9] = f.ca_fall[9];
		end else begin
			for (int i = 0; i < 8; i++) begin
				train_map[2*i] = sel_r[i];
				train_map[2*i+1] = sel_f[i];
			end
		end
	endfunction : train_map

	sdtc_pkg::sdtc_mrw_s mrw;
	logic is_mrw, is_ent, is_ext, is_map, is_mr2, is_mr11;
	assign mrw = mrw_fields(frame_r);
	assign is_mrw = frame_r.cs_low && frame_r.ca_rise[3:0] == 4'h0;
	assign is_ent = is_mrw && mrw.addr == sdtc_pkg::MA_TRAIN_ENTER
		&& mrw.data == sdtc_pkg::OP_TRAIN_ENTER;
	assign is_ext = is_mrw && mrw.addr == sdtc_pkg::MA_TRAIN_EXIT
		&& mrw.data == sdtc_pkg::OP_TRAIN_EXIT;
	assign is_map = is_mrw && mrw.addr == sdtc_pkg::MA_TRAIN_MAP2
		&& mrw.data == sdtc_pkg::OP_TRAIN_MAP2;
	assign is_mr2 = is_mrw && mrw.addr == sdtc_pkg::MA_FEATURE2;
	assign is_mr11 = is_mrw && mrw.addr == sdtc_pkg::MA_TERM_CTRL;

	// Training mode and mapping
	logic ca_train_r, map2_r;
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			ca_train_r <= 1'b0;
			map2_r <= 1'b0;
		end else if (clk_en && ev) begin
			if (is_ent) begin
				ca_train_r <= 1'b1;
				map2_r <= 1'b0;
			end else if (is_ext && ca_train_r) begin
				ca_train_r <= 1'b0;
				map2_r <= 1'b0;
			end else if (is_map && ca_train_r && frame_r.cke) begin
				map2_r <= 1'b1;
			end
		end
	end

	// Write leveling and termination configuration
	logic wl_r;
	logic [2:0] mr11_r;
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			wl_r <= 1'b0;
			mr11_r <= sdtc_pkg::TERM_CTRL_RST;
		end else if (clk_en && ev && !ca_train_r) begin
			if (is_mr2)
				wl_r <= mrw.data[sdtc_pkg::WL_BIT];
			if (is_mr11)
				mr11_r <= mrw.data[2:0];
		end
	end

	// Data pins: training result or leveling feedback
	logic [sdtc_pkg::DQ_W-1:0] dq_r;
	logic dq_oe_r;
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			dq_r <= sdtc_pkg::DQ_RST;
		end else if (clk_en) begin
			if (ca_train_r && ev && frame_r.cs_low && !is_mrw)
				dq_r <= train_map(frame_r, map2_r);
			else if (wl_r) begin
				for (int b = 0; b < sdtc_pkg::BYTES; b++)
					if (dqs_rise[b])
						dq_r[8*b +: 8] <= {8{ck_s_r[1]}};
			end
		end
	end

	// Strobes are never driven here, so they stay static in training
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n)
			dq_oe_r <= 1'b0;
		else if (clk_en)
			dq_oe_r <= (ca_train_r || wl_r) && !zq_busy;
	end

	// Termination; the pin itself is unclocked, a two-flop copy is used here
	logic term_ok;
	assign term_ok = odt_s_r[1] && mr11_r[1:0] != 2'h0 && !read_active
		&& !self_refresh && !deep_pd && !ca_train_r
		&& !(cke_pd && !mr11_r[sdtc_pkg::TERM_PD_BIT]);

	logic dq_term_r, dqs_term_r;
	logic [1:0] rtt_r;
	always_ff @(posedge ref_clk or negedge rst_ok_n) begin
		if (!rst_ok_n) begin
			dq_term_r <= 1'b0;
			dqs_term_r <= 1'b0;
			rtt_r <= 2'h0;
		end else if (clk_en) begin
			dq_term_r <= term_ok && !wl_r && !zq_busy;
			dqs_term_r <= term_ok && !zq_busy;
			rtt_r <= mr11_r[1:0];
		end
	end

	assign dq_o = dq_r;
	assign dq_oe = dq_oe_r;
	assign dq_term_en = dq_term_r;
	assign dqs_term_en = dqs_term_r;
	assign rtt_sel = rtt_r;
	assign ca_training = ca_train_r;
	assign write_leveling = wl_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_ok_n);

	// Training mode and mapping
	a_train_entry: assert property (clk_en && ev && is_ent |=> ca_train_r && !map2_r)
		else $error("training entry not taken");
	a_train_exit: assert property (clk_en && ev && is_ext |=> !ca_train_r && !map2_r)
		else $error("training exit not taken");
	a_map_switch: assert property (clk_en && ev && is_map && ca_train_r && frame_r.cke
		|=> map2_r)
		else $error("mapping switch not taken");
	a_map_refused: assert property (clk_en && ev && is_map && !frame_r.cke && !map2_r
		|=> !map2_r)
		else $error("mapping switch taken with clock enable low");
	a_map_order: assert property (map2_r |-> ca_train_r)
		else $error("second mapping outside training");
	a_mr_locked: assert property (clk_en && ev && ca_train_r
		|=> mr11_r == $past(mr11_r) && wl_r == $past(wl_r))
		else $error("register write taken during training");
	a_map1_data: assert property (clk_en && ev && ca_train_r && !map2_r && frame_r.cs_low
		&& !is_mrw |=> dq_r[0] == $past(frame_r.ca_rise[0])
		&& dq_r[15] == $past(frame_r.ca_fall[8]))
		else $error("first mapping data wrong");
	a_map1_mid: assert property (clk_en && ev && ca_train_r && !map2_r && frame_r.cs_low
		&& !is_mrw |=> dq_r[8] == $past(frame_r.ca_rise[5])
		&& dq_r[9] == $past(frame_r.ca_fall[5]))
		else $error("first mapping middle pins wrong");
	a_map2_data: assert property (clk_en && ev && map2_r && frame_r.cs_low && !is_mrw
		|=> dq_r[8] == $past(frame_r.ca_rise[9]) && dq_r[1] == $past(frame_r.ca_fall[4])
		&& dq_r[15:10] == 6'h00)
		else $error("second mapping data wrong");
	a_train_oe: assert property (clk_en && ca_train_r && !zq_busy |=> dq_oe_r)
		else $error("training data not driven");
	a_dq_quiet: assert property (clk_en && ev && !frame_r.cs_low && !wl_r |=> $stable(dq_r))
		else $error("data changed on deselected frame");

	// Leveling and termination
	a_wl_mode: assert property (clk_en && ev && is_mr2 && !ca_train_r
		|=> wl_r == $past(mrw.data[7]))
		else $error("leveling mode mismatch");
	a_wl_feedback: assert property (clk_en && wl_r && !ca_train_r && dqs_rise[1]
		|=> dq_r[15:8] == {8{$past(ck_s_r[1])}})
		else $error("leveling feedback wrong");
	a_term_block: assert property (clk_en && (read_active || self_refresh || deep_pd
		|| ca_train_r) |=> !dq_term_r && !dqs_term_r)
		else $error("termination not blocked");
	a_term_pd: assert property (clk_en && cke_pd && !mr11_r[sdtc_pkg::TERM_PD_BIT]
		|=> !dq_term_r && !dqs_term_r)
		else $error("termination in power-down without option");
	a_wl_dq_term: assert property (clk_en && wl_r |=> !dq_term_r)
		else $error("data termination during leveling");
	a_zq_quiet: assert property (clk_en && zq_busy
		|=> !dq_oe_r && !dq_term_r && !dqs_term_r)
		else $error("bus not quiet during calibration");
	a_term_mode: assert property (clk_en && mr11_r[1:0] == 2'h0 |=> !dqs_term_r)
		else $error("termination with mode off");
	a_rtt_follow: assert property (clk_en |=> rtt_r == $past(mr11_r[1:0]))
		else $error("resistance select stale");

	// Main scenarios
	c_train_pass: cover property (map2_r ##1 !ca_train_r);
	c_map_refused: cover property (ev && is_map && ca_train_r && !frame_r.cke);
	c_wl_sample: cover property (wl_r && dqs_rise[0]);
	c_term_on: cover property (dq_term_r);
	c_term_pd: cover property (dq_term_r && cke_pd);

endmodule : sdtc_core

`default_nettype wire

// File: rtl/sdtc_pkg.sv
// Constants and carriers for the training and calibration mode logic.
// Assumes a 16-bit data bus in two bytes and a 10-bit command/address bus.
// Function
// - Training order: enter, first map, switch, exit
// - Unused data pins valid, strobes static
// - Training output timed from clock falling edge
// - Entry write: address 29H, operand A4H
// - Exit write: address 2AH, operand A8H
// - Mapping switch: address 30H, operand C0H
// - First mapping: even rise, odd fall pins
// - Second mapping: CA4 on 0/1, CA9 8/9
// - Register 2 bit 7 controls write leveling
// - Strobe rise samples clock onto its byte
// - Termination pin ignored in listed states
// - Register write decode from both edges
// - Register 11 enables, sizes, power-down option

package sdtc_pkg;
	localparam int CA_W = 10;
	localparam int DQ_W = 16;
	localparam int BYTES = 2;
	localparam logic [7:0] MA_TRAIN_ENTER = 8'h29;
	localparam logic [7:0] OP_TRAIN_ENTER = 8'hA4;
	localparam logic [7:0] MA_TRAIN_EXIT = 8'h2A;
	localparam logic [7:0] OP_TRAIN_EXIT = 8'hA8;
	localparam logic [7:0] MA_TRAIN_MAP2 = 8'h30;
	localparam logic [7:0] OP_TRAIN_MAP2 = 8'hC0;
	localparam logic [7:0] MA_FEATURE2 = 8'h02;
	localparam int WL_BIT = 7;
	localparam logic [7:0] MA_TERM_CTRL = 8'h0B;
	localparam int TERM_PD_BIT = 2;
	localparam logic [2:0] TERM_CTRL_RST = 3'h0;
	localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;

	typedef struct packed {
		logic cs_low;
		logic cke;
		logic [CA_W-1:0] ca_rise;
		logic [CA_W-1:0] ca_fall;
	} sdtc_frame_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sdtc_mrw_s;
endpackage : sdtc_pkg

// File: verif/sdtc_ctrl_model.sv
// Controller model: command frames, leveling strobes.
// Assumes the bench calls its tasks; clock stands still between frames.
`timescale 1ns/1ns
`default_nettype none

module sdtc_ctrl_model (
	output var logic mem_clk,
	output var logic cs_n,
	output var logic cke,
	output var logic [9:0] ca,
	output var logic [1:0] dqs_t
);
	initial begin
		mem_clk = 1'b0;
		cs_n = 1'b1;
		cke = 1'b1;
		ca = 10'h000;
		dqs_t = 2'h0; // Parked low until pulsed
	end

	// Bus set a quarter period ahead of the rise
	task automatic frame(input logic sel_n, input logic [9:0] r, input logic [9:0] f);
		cs_n = sel_n;
		ca = r;
		#40 mem_clk = 1'b1;
		#40 ca = f;
		#40 mem_clk = 1'b0;
		#20 cs_n = 1'b1;
		ca = ~f; // Released bus shows no stale value
		#20; // Next frame never reassigns in this time step
	endtask : frame

	// Mapping switch refused while this is low
	task automatic set_cke(input logic v);
		cke = v;
	endtask : set_cke

	// Only single writes, one at a time
	task automatic mrw(input logic [7:0] a, input logic [7:0] d);
		frame(1'b0, {a[5:0], 4'h0}, {d, a[7:6]});
	endtask : mrw

	// Clock held at lvl while one strobe pulses
	task automatic strobe(input int b, input logic lvl);
		mem_clk = lvl;
		#40 dqs_t[b] = 1'b1;
		#40 dqs_t[b] = 1'b0;
		#80 mem_clk = 1'b0;
	endtask : strobe
endmodule : sdtc_ctrl_model
`default_nettype wire

// File: verif/sdtc_core_tb.sv
// Bench for the training, leveling and termination core.
// Assumes the controller model drives the link side.
`timescale 1ns/1ns
`default_nettype none

module sdtc_core_tb;
	logic ref_clk, rst_n, odt_pin, mem_clk, cs_n, cke, clk_en;
	logic [4:0] st;
	logic [9:0] ca;
	logic [1:0] dqs_t, rtt_sel;
	logic [15:0] dq_o;
	logic dq_oe, dq_term_en, dqs_term_en, ca_training, write_leveling;
	int bad_count = 0;
	int num_checks = 0;

	sdtc_ctrl_model ctl (.mem_clk, .cs_n, .cke, .ca, .dqs_t);
	sdtc_core dut (.ref_clk, .rst_n, .clk_en, .mem_clk, .cs_n, .cke, .ca,
		.odt_pin, .dqs_t, .zq_busy(st[4]), .cke_pd(st[3]), .deep_pd(st[2]),
		.self_refresh(st[1]), .read_active(st[0]), .dq_o, .dq_oe, .dq_term_en,
		.dqs_term_en, .rtt_sel, .ca_training, .write_leveling);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (12) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic t_odt();
		ctl.mrw(8'h0B, 8'h03);
		@(posedge ref_clk) odt_pin <= 1'b1;
		settle();
		chk(dq_term_en, 1'b1);
		chk(rtt_sel, 2'h3);
		// Frozen state must ignore the pin
		@(posedge ref_clk);
		clk_en <= 1'b0;
		odt_pin <= 1'b0;
		settle();
		chk(dq_term_en, 1'b1);
		@(posedge ref_clk) clk_en <= 1'b1;
		settle();
		chk(dq_term_en, 1'b0);
		@(posedge ref_clk) odt_pin <= 1'b1;
		// No frames sent while calibrating
		for (int k = 0; k < 5; k++) begin
			@(posedge ref_clk) st <= 5'h01 << k;
			settle();
			chk({dq_term_en, dqs_term_en, dq_oe}, 3'h0);
		end
		// Power-down option keeps termination on
		@(posedge ref_clk) st <= 5'h08;
		ctl.mrw(8'h0B, 8'h07);
		settle();
		chk(dq_term_en, 1'b1);
		@(posedge ref_clk) st <= 5'h00;
		$display("t_odt done");
	endtask : t_odt

	task automatic t_wl();
		ctl.mrw(8'h02, 8'h80);
		settle();
		chk(write_leveling, 1'b1);
		@(posedge ref_clk) st <= 5'h10;
		settle();
		chk({dq_oe, dqs_term_en}, 2'h0);
		@(posedge ref_clk) st <= 5'h00;
		settle();
		chk({dq_oe, dq_term_en, dqs_term_en}, 3'h5);
		ctl.strobe(0, 1'b1);
		settle();
		chk(dq_o[7:0], 8'hFF);
		ctl.strobe(1, 1'b1);
		settle();
		chk(dq_o, 16'hFFFF);
		ctl.strobe(0, 1'b0);
		settle();
		chk(dq_o, 16'hFF00);
		ctl.mrw(8'h02, 8'h00);
		ctl.mrw(8'h0B, 8'h00);
		settle();
		chk({write_leveling, dqs_term_en}, 2'h0);
		$display("t_wl done");
	endtask : t_wl

	task automatic t_train();
		logic [9:0] r = 10'h2B5;
		logic [9:0] f = 10'h14A;
		logic [15:0] e;
		int idx[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
		ctl.mrw(8'h29, 8'hA4);
		settle();
		chk(ca_training, 1'b1);
		ctl.frame(1'b0, r, f);
		settle();
		for (int i = 0; i < 8; i++) begin
			e[2*i] = r[idx[i]];
			e[2*i+1] = f[idx[i]];
		end
		chk(dq_o, e);
		chk(dq_oe, 1'b1);
		ctl.set_cke(1'b0);
		ctl.mrw(8'h30, 8'hC0);
		ctl.set_cke(1'b1);
		ctl.frame(1'b0, r, f);
		settle();
		chk(dq_o, e);
		ctl.mrw(8'h30, 8'hC0);
		ctl.frame(1'b0, r, f);
		settle();
		e = 16'h0000;
		e[0] = r[4];
		e[1] = f[4];
		e[8] = r[9];
		e[9] = f[9];
		chk(dq_o, e);
		ctl.mrw(8'h2A, 8'hA8);
		settle();
		chk(ca_training, 1'b0);
		$display("t_train done");
	endtask : t_train

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		odt_pin = 1'b0;
		st = 5'h00;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Deselected cycles let the link side leave reset
		repeat (3) ctl.frame(1'b1, 10'h3FF, 10'h3FF);
		t_odt();
		t_wl();
		t_train();
		wrap_up();
	end

	// About 25 times the expected run
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
endmodule : sdtc_core_tb
`default_nettype wire
